// File: rtl/dac_cfg_defines.svh
`ifndef DAC_CFG_DEFINES_SVH
`define DAC_CFG_DEFINES_SVH

// Register offsets on the serial configuration port
`define ADDR_SERIAL_PORT_POWER_CONFIG 5'h00
`define ADDR_DATAPATH_CONTROL_A       5'h01
`define ADDR_DATAPATH_CONTROL_B       5'h02
`define ADDR_DATA_CLOCK_DELAY_LOW     5'h04

// Reset values
`define RST_SERIAL_PORT_POWER_CONFIG  8'h00
`define RST_DATAPATH_CONTROL_A        8'h00
`define RST_DATAPATH_CONTROL_B        8'h00
`define RST_DATA_CLOCK_DELAY_LOW      8'h00

// Writable bits of the port and power register; bit 1 is the lock flag
`define SERIAL_PORT_POWER_WR_MASK     8'hF8

// Field positions, port and power register
`define BIT_SDIO_BIDIR                7
`define BIT_LSB_FIRST                 6
`define BIT_SOFT_RESET                5
`define BIT_POWER_DOWN                4
`define BIT_AUTO_POWER_DOWN           3
`define BIT_PLL_LOCKED                1

// Field positions, datapath control A
`define MSB_INTERP_FACTOR             7
`define LSB_INTERP_FACTOR             6
`define MSB_FILTER_MODE               5
`define LSB_FILTER_MODE               2
`define BIT_DCLK_DELAY_MSB            1
`define BIT_ZERO_STUFF                0

// Field positions, datapath control B
`define BIT_DATA_FORMAT               7
`define BIT_SINGLE_PORT               6
`define BIT_REAL_MODE                 5
`define BIT_DCLK_DELAY_EN             4
`define BIT_INV_SINC                  3
`define BIT_DCLK_INVERT               2
`define BIT_TX_ENABLE_INVERT          1
`define BIT_Q_FIRST                   0

// Field position, delay low register
`define MSB_DCLK_DELAY_LOW            7
`define LSB_DCLK_DELAY_LOW            4

// Serial framing
`define BIT_INSTR_READ                7
`define MSB_INSTR_ADDR                4
`define LAST_BIT_INDEX                3'h7

`endif

// File: rtl/dac_cfg_pkg.sv
package dac_cfg_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_READ  = 4'b1000
  } port_state_t;

  typedef struct packed {
    logic       power_down;
    logic       auto_power_down_en;
    logic       circuitry_enable;
    logic [1:0] interp_factor;
    logic [3:0] filter_mode;
    logic       zero_stuff_en;
    logic       data_format_unsigned;
    logic       single_port;
    logic       second_port_enable;
    logic       real_mode;
    logic       q_clock_enable;
    logic       modulator_enable;
    logic [4:0] data_clock_delay;
    logic       inverse_sinc_en;
    logic       data_clock_invert;
    logic       tx_enable_invert;
    logic       q_first;
  } datapath_cfg_t;

  typedef struct packed {
    port_state_t   state;
    logic [2:0]    bit_cnt;
    logic [7:0]    shift;
    logic [4:0]    addr;
    logic [7:0]    out_shift;
    logic          sdio_out;
    logic          sdio_oe;
    logic          sdo_out;
    logic          sdo_oe;
    logic [7:0]    serial_port_power_config;
    logic [7:0]    datapath_control_a;
    logic [7:0]    datapath_control_b;
    logic [7:0]    data_clock_delay_low;
    datapath_cfg_t cfg;
    logic          transmit_enable_eff;
  } core_state_t;

endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output      logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t sync_reg;
  sync_state_t sync_next;

  // Stage one feeds stage two only, so metastability never reaches logic
  always_comb
  begin
    sync_next        = sync_reg;
    sync_next.stage1 = d;
    sync_next.stage2 = sync_reg.stage1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_reg <= '0;
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.stage2;

endmodule

// File: rtl/edge_detect.sv
`timescale 1ns/1ns
module edge_detect (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic level,
  output      logic rise,
  output      logic fall
);

  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t edge_reg;
  edge_state_t edge_next;

  always_comb
  begin
    edge_next      = edge_reg;
    edge_next.prev = level;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      edge_reg <= '0;
    end
    else
    begin
      edge_reg <= edge_next;
    end
  end

  assign rise = level & ~edge_reg.prev;
  assign fall = ~level & edge_reg.prev;

endmodule

// File: rtl/dac_comm_digital_ctrl_regs.sv
// Functional notes
// RULE_01 - Port bit 7 clear: data pin input only; set: pin also returns read data.
// RULE_02 - Port bit 6 picks serial bit order: 0 MSB first, 1 LSB first.
// RULE_03 - Writing bit 5 as 1 then 0 soft resets the configuration registers.
// RULE_04 - Port bit 4 powers down everything except the serial port.
// RULE_05 - Port bit 3 enables automatic power-down.
// RULE_06 - Port bit 1 reads the PLL lock state, read only.
// RULE_07 - Control A bit 1 is the top bit of the data clock delay.
// RULE_08 - Control A bit 0 turns zero stuffing off or on.
// RULE_09 - Control B bit 6 set takes both channels from the first data port.
// RULE_10 - Control B bit 5 set disables Q data, Q clocks and both modulators.
// RULE_11 - Control B bit 4 enables the data clock delay; clear means no delay.
// RULE_12 - Control B bit 3 inserts the inverse sinc filter, clear bypasses it.
// RULE_13 - Control B bit 2 drives the data clock in phase or inverted.
// RULE_14 - Control B bit 1 inverts transmit enable / IQ select polarity.
// RULE_15 - Control B bit 0 sets interleave order: 0 I first, 1 Q first.
// RULE_16 - Delay bits 3:0 come from bits 7:4 at offset 0x04, five bits total.
// RULE_17 - Lock flag writes ignored; soft reset restores every writable field.
`timescale 1ns/1ns
`include "dac_cfg_defines.svh"
module dac_comm_digital_ctrl_regs (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       sclk,
  input  wire logic                       cs_n,
  input  wire logic                       sdio_in,
  output      logic                       sdio_out,
  output      logic                       sdio_oe,
  output      logic                       sdo_out,
  output      logic                       sdo_oe,
  input  wire logic                       pll_locked,
  input  wire logic                       transmit_enable_in,
  output      logic                       transmit_enable_eff,
  output      dac_cfg_pkg::datapath_cfg_t datapath_cfg
);

  localparam int PIN_COUNT = 5;

  dac_cfg_pkg::core_state_t core_reg;
  dac_cfg_pkg::core_state_t core_next;

  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins_sync;
  logic                 sclk_s;
  logic                 cs_n_s;
  logic                 sdio_s;
  logic                 pll_s;
  logic                 tx_s;
  logic                 sclk_rise;
  logic                 sclk_fall;

  logic [7:0]           shifted;
  logic [7:0]           in_byte;
  logic [7:0]           rd_byte;
  logic [7:0]           out_byte;
  logic [7:0]           instr_byte;
  logic [4:0]           rd_addr;
  logic                 lsb_first;
  logic                 bidir;
  logic                 do_write;
  logic                 tx_level;
  logic                 active;

  // Every pin comes from outside the clock domain; chip select crosses inverted so a
  // cleared synchroniser reads as deselected and no false frame follows reset
  assign pins_raw = {sclk, ~cs_n, sdio_in, pll_locked, transmit_enable_in};

  pin_sync #(
    .WIDTH (PIN_COUNT)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (pins_raw),
    .q       (pins_sync)
  );

  assign sclk_s = pins_sync[4];
  assign cs_n_s = ~pins_sync[3];
  assign sdio_s = pins_sync[2];
  assign pll_s  = pins_sync[1];
  assign tx_s   = pins_sync[0];

  edge_detect u_sclk_edge (
    .ref_clk (ref_clk),
    .rst     (rst),
    .level   (sclk_s),
    .rise    (sclk_rise),
    .fall    (sclk_fall)
  );

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  // Readback mux; reserved port register bits and unmapped offsets read zero, delay low bits 3:0 read back as written
  always_comb
  begin
    rd_byte    = 8'h00;
    instr_byte = {core_reg.shift[6:0], sdio_s};
    if (core_reg.serial_port_power_config[`BIT_LSB_FIRST])
    begin
      instr_byte = reverse8(instr_byte);
    end
    // The first read bit leaves on the edge that completes the instruction, before the
    // address register is loaded, so the address is decoded from the shifter then
    rd_addr = core_reg.addr;
    if (core_reg.state == dac_cfg_pkg::ST_INSTR)
    begin
      rd_addr = instr_byte[`MSB_INSTR_ADDR:0];
    end
    case (rd_addr)
      `ADDR_SERIAL_PORT_POWER_CONFIG:
      begin
        rd_byte                  = core_reg.serial_port_power_config & `SERIAL_PORT_POWER_WR_MASK;
        rd_byte[`BIT_PLL_LOCKED] = pll_s; // RULE_06
      end
      `ADDR_DATAPATH_CONTROL_A:
      begin
        rd_byte = core_reg.datapath_control_a;
      end
      `ADDR_DATAPATH_CONTROL_B:
      begin
        rd_byte = core_reg.datapath_control_b;
      end
      `ADDR_DATA_CLOCK_DELAY_LOW:
      begin
        rd_byte = core_reg.data_clock_delay_low;
      end
      default:
      begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always_comb
  begin
    core_next = core_reg;
    shifted   = {core_reg.shift[6:0], sdio_s};
    lsb_first = core_reg.serial_port_power_config[`BIT_LSB_FIRST];
    bidir     = core_reg.serial_port_power_config[`BIT_SDIO_BIDIR];
    // Bit order applies to instruction and data bytes alike
    in_byte   = lsb_first ? reverse8(shifted) : shifted; // RULE_02
    out_byte  = lsb_first ? reverse8(rd_byte) : rd_byte; // RULE_02
    do_write  = 1'b0;
    tx_level  = 1'b0;
    active    = 1'b0;

    case (core_reg.state)
      dac_cfg_pkg::ST_IDLE:
      begin
        core_next.bit_cnt = 3'h0;
        if (!cs_n_s)
        begin
          core_next.state = dac_cfg_pkg::ST_INSTR;
        end
      end
      dac_cfg_pkg::ST_INSTR:
      begin
        if (sclk_rise)
        begin
          core_next.shift   = shifted;
          core_next.bit_cnt = core_reg.bit_cnt + 3'h1;
          if (core_reg.bit_cnt == `LAST_BIT_INDEX)
          begin
            core_next.addr = in_byte[`MSB_INSTR_ADDR:0];
            if (in_byte[`BIT_INSTR_READ])
            begin
              core_next.state = dac_cfg_pkg::ST_READ;
            end
            else
            begin
              core_next.state = dac_cfg_pkg::ST_WRITE;
            end
          end
        end
      end
      dac_cfg_pkg::ST_WRITE:
      begin
        if (sclk_rise)
        begin
          core_next.shift   = shifted;
          core_next.bit_cnt = core_reg.bit_cnt + 3'h1;
          if (core_reg.bit_cnt == `LAST_BIT_INDEX)
          begin
            do_write        = 1'b1;
            core_next.state = dac_cfg_pkg::ST_INSTR;
          end
        end
      end
      dac_cfg_pkg::ST_READ:
      begin
        if (sclk_rise)
        begin
          core_next.bit_cnt = core_reg.bit_cnt + 3'h1;
          if (core_reg.bit_cnt == `LAST_BIT_INDEX)
          begin
            core_next.state  = dac_cfg_pkg::ST_INSTR;
            core_next.sdio_oe = 1'b0;
            core_next.sdo_oe  = 1'b0;
          end
        end
        else if (sclk_fall && core_reg.bit_cnt != 3'h0)
        begin
          core_next.sdio_out  = core_reg.out_shift[7];
          core_next.sdo_out   = core_reg.out_shift[7];
          core_next.out_shift = {core_reg.out_shift[6:0], 1'b0};
        end
      end
      default:
      begin
        core_next.state = dac_cfg_pkg::ST_IDLE;
      end
    endcase

    // First read bit goes out right after the instruction byte completes
    if (core_reg.state == dac_cfg_pkg::ST_INSTR && sclk_rise &&
        core_reg.bit_cnt == `LAST_BIT_INDEX && in_byte[`BIT_INSTR_READ])
    begin
      core_next.sdio_out  = out_byte[7];
      core_next.sdo_out   = out_byte[7];
      core_next.out_shift = {out_byte[6:0], 1'b0};
      core_next.sdio_oe   = bidir;  // RULE_01
      core_next.sdo_oe    = ~bidir; // RULE_01
    end

    // Chip select high aborts any frame and frees the data pins
    if (cs_n_s)
    begin
      core_next.state   = dac_cfg_pkg::ST_IDLE;
      core_next.bit_cnt = 3'h0;
      core_next.sdio_oe = 1'b0;
      core_next.sdo_oe  = 1'b0;
    end

    if (do_write)
    begin
      case (core_reg.addr)
        `ADDR_SERIAL_PORT_POWER_CONFIG:
        begin
          // The lock flag and reserved bits are not storage
          core_next.serial_port_power_config = in_byte & `SERIAL_PORT_POWER_WR_MASK; // RULE_17
          if (core_reg.serial_port_power_config[`BIT_SOFT_RESET] &&
              !in_byte[`BIT_SOFT_RESET])
          begin
            core_next.serial_port_power_config = `RST_SERIAL_PORT_POWER_CONFIG; // RULE_03
            core_next.datapath_control_a       = `RST_DATAPATH_CONTROL_A;       // RULE_17
            core_next.datapath_control_b       = `RST_DATAPATH_CONTROL_B;       // RULE_17
            core_next.data_clock_delay_low     = `RST_DATA_CLOCK_DELAY_LOW;     // RULE_17
          end
        end
        `ADDR_DATAPATH_CONTROL_A:
        begin
          core_next.datapath_control_a = in_byte;
        end
        `ADDR_DATAPATH_CONTROL_B:
        begin
          core_next.datapath_control_b = in_byte;
        end
        `ADDR_DATA_CLOCK_DELAY_LOW:
        begin
          core_next.data_clock_delay_low = in_byte;
        end
        default:
        begin
          core_next.addr = core_reg.addr;
        end
      endcase
    end

    // Datapath controls follow the next register contents, so they update on the same edge
    core_next.cfg.power_down =
      core_next.serial_port_power_config[`BIT_POWER_DOWN]; // RULE_04
    core_next.cfg.auto_power_down_en =
      core_next.serial_port_power_config[`BIT_AUTO_POWER_DOWN]; // RULE_05
    tx_level = tx_s ^ core_next.datapath_control_b[`BIT_TX_ENABLE_INVERT]; // RULE_14
    // Auto power-down idles the datapath while transmit is not enabled
    active = ~core_next.cfg.power_down &
             ~(core_next.cfg.auto_power_down_en & ~tx_level); // RULE_04 RULE_05
    core_next.cfg.circuitry_enable = active;
    core_next.transmit_enable_eff  = tx_level & ~core_next.cfg.power_down; // RULE_04

    core_next.cfg.interp_factor =
      core_next.datapath_control_a[`MSB_INTERP_FACTOR:`LSB_INTERP_FACTOR];
    core_next.cfg.filter_mode =
      core_next.datapath_control_a[`MSB_FILTER_MODE:`LSB_FILTER_MODE];
    core_next.cfg.zero_stuff_en =
      core_next.datapath_control_a[`BIT_ZERO_STUFF]; // RULE_08

    core_next.cfg.data_format_unsigned =
      core_next.datapath_control_b[`BIT_DATA_FORMAT];
    core_next.cfg.single_port =
      core_next.datapath_control_b[`BIT_SINGLE_PORT]; // RULE_09
    core_next.cfg.second_port_enable =
      active & ~core_next.datapath_control_b[`BIT_SINGLE_PORT]; // RULE_09
    core_next.cfg.real_mode =
      core_next.datapath_control_b[`BIT_REAL_MODE]; // RULE_10
    core_next.cfg.q_clock_enable =
      active & ~core_next.datapath_control_b[`BIT_REAL_MODE]; // RULE_10
    core_next.cfg.modulator_enable =
      active & ~core_next.datapath_control_b[`BIT_REAL_MODE]; // RULE_10

    // A clear enable forces zero delay whatever the delay fields hold
    if (core_next.datapath_control_b[`BIT_DCLK_DELAY_EN]) // RULE_11
    begin
      core_next.cfg.data_clock_delay = {
        core_next.datapath_control_a[`BIT_DCLK_DELAY_MSB], // RULE_07
        core_next.data_clock_delay_low[`MSB_DCLK_DELAY_LOW:`LSB_DCLK_DELAY_LOW] // RULE_16
      };
    end
    else
    begin
      core_next.cfg.data_clock_delay = 5'h00; // RULE_11
    end

    core_next.cfg.inverse_sinc_en =
      core_next.datapath_control_b[`BIT_INV_SINC]; // RULE_12
    core_next.cfg.data_clock_invert =
      core_next.datapath_control_b[`BIT_DCLK_INVERT]; // RULE_13
    core_next.cfg.tx_enable_invert =
      core_next.datapath_control_b[`BIT_TX_ENABLE_INVERT]; // RULE_14
    core_next.cfg.q_first =
      core_next.datapath_control_b[`BIT_Q_FIRST]; // RULE_15
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      core_reg                          <= '0;
      core_reg.state                    <= dac_cfg_pkg::ST_IDLE;
      core_reg.serial_port_power_config <= `RST_SERIAL_PORT_POWER_CONFIG;
      core_reg.datapath_control_a       <= `RST_DATAPATH_CONTROL_A;
      core_reg.datapath_control_b       <= `RST_DATAPATH_CONTROL_B;
      core_reg.data_clock_delay_low     <= `RST_DATA_CLOCK_DELAY_LOW;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  assign sdio_out            = core_reg.sdio_out;
  assign sdio_oe             = core_reg.sdio_oe;
  assign sdo_out             = core_reg.sdo_out;
  assign sdo_oe              = core_reg.sdo_oe;
  assign transmit_enable_eff = core_reg.transmit_enable_eff;
  assign datapath_cfg        = core_reg.cfg;

endmodule

// File: test/dac_ctrl_assertions.sv
`timescale 1ns/1ns
module dac_ctrl_assertions (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       cs_n,
  input wire logic                       sdio_out,
  input wire logic                       sdio_oe,
  input wire logic                       sdo_out,
  input wire logic                       sdo_oe,
  input wire logic                       transmit_enable_in,
  input wire logic                       transmit_enable_eff,
  input wire dac_cfg_pkg::datapath_cfg_t datapath_cfg
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  dac_cfg_pkg::datapath_cfg_t c;
  assign c = datapath_cfg;

  // Pin and invert bit both settled long enough to cross the synchroniser
  sequence te_still;
    ($stable(transmit_enable_in) && $stable(c.tx_enable_invert) && !c.power_down) [*5];
  endsequence
  sequence cs_idle;
    cs_n [*8];
  endsequence

  a_oe_exclusive: assert property (!(sdio_oe && sdo_oe))
    else $error("both read pins driven");
  a_pin_match: assert property (sdio_oe |-> sdio_out == sdo_out)
    else $error("read pins disagree");
  a_oe_release: assert property ($rose(cs_n) |-> ##[0:8] !(sdio_oe || sdo_oe))
    else $error("read pin held after deselect");
  a_pd_gates: assert property (c.power_down |->
    !c.circuitry_enable && !c.second_port_enable
    && !c.q_clock_enable && !c.modulator_enable && !transmit_enable_eff)
    else $error("power-down left circuitry on");
  // Outputs still hold their reset values at the first edge after release
  a_cfg_live: assert property (!$past(rst) && !c.power_down && !c.auto_power_down_en |->
    c.circuitry_enable && c.q_clock_enable == !c.real_mode
    && c.second_port_enable == !c.single_port)
    else $error("circuitry off without power-down");
  a_real_mode: assert property (c.real_mode |-> !c.q_clock_enable && !c.modulator_enable)
    else $error("Q path live in real mode");
  a_single_port: assert property (c.single_port |-> !c.second_port_enable)
    else $error("second port live in single port mode");
  a_tx_polarity: assert property (te_still |->
    transmit_enable_eff == (transmit_enable_in ^ c.tx_enable_invert))
    else $error("transmit enable polarity wrong");
  a_cfg_quiet: assert property (cs_idle |=> $stable({c.interp_factor, c.filter_mode,
    c.zero_stuff_en, c.q_first, c.inverse_sinc_en}))
    else $error("config changed while port idle");
endmodule

bind dac_comm_digital_ctrl_regs dac_ctrl_assertions u_chk (
  .ref_clk             (ref_clk),
  .rst                 (rst),
  .cs_n                (cs_n),
  .sdio_out            (sdio_out),
  .sdio_oe             (sdio_oe),
  .sdo_out             (sdo_out),
  .sdo_oe              (sdo_oe),
  .transmit_enable_in  (transmit_enable_in),
  .transmit_enable_eff (transmit_enable_eff),
  .datapath_cfg        (datapath_cfg)
);

// File: test/serial_host.sv
`timescale 1ns/1ns
module serial_host (
  input  wire logic ref_clk,
  output      logic sclk,
  output      logic cs_n,
  output      logic host_d,
  input  wire logic sdio_wire,
  input  wire logic sdo_out,
  input  wire logic sdo_oe
);
  int   half = 5;
  logic lsb_first = 1'b0;
  logic bidir = 1'b0;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_d = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic xbyte(input logic drive, input logic [7:0] tx, output logic [7:0] rx);
    int k;
    rx = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      k = lsb_first ? i : 7 - i;
      // A released line toggles so a stale level cannot pass for data
      host_d <= drive ? tx[k] : ~host_d;
      wait_clk(half);
      sclk <= 1'b1;
      rx[k] = bidir ? sdio_wire : (sdo_oe ? sdo_out : ~host_d);
      wait_clk(half);
      sclk <= 1'b0;
    end
  endtask

  task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] junk;
    cs_n <= 1'b0;
    wait_clk(half);
    xbyte(1'b1, {rd, 2'b00, a}, junk);
    xbyte(!rd, d, q);
    wait_clk(half);
    cs_n <= 1'b1;
    wait_clk(2 * half);
  endtask
endmodule

// File: test/tb_dac_comm_digital_ctrl_regs.sv
`timescale 1ns/1ns
module tb_dac_comm_digital_ctrl_regs;
  logic                       ref_clk = 1'b0;
  logic                       rst = 1'b1;
  logic                       pll_locked = 1'b0;
  logic                       transmit_enable_in = 1'b0;
  logic                       sclk;
  logic                       cs_n;
  logic                       host_d;
  logic                       sdio_wire;
  logic                       sdio_out;
  logic                       sdio_oe;
  logic                       sdo_out;
  logic                       sdo_oe;
  logic                       transmit_enable_eff;
  dac_cfg_pkg::datapath_cfg_t cfg;
  logic [7:0]                 rx;
  int                         fails = 0;
  int                         tests_run = 0;

  always #25 ref_clk = ~ref_clk;
  assign sdio_wire = sdio_oe ? sdio_out : host_d;

  dac_comm_digital_ctrl_regs dut (
    .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_wire),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .pll_locked(pll_locked), .transmit_enable_in(transmit_enable_in),
    .transmit_enable_eff(transmit_enable_eff), .datapath_cfg(cfg)
  );

  serial_host host (
    .ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .host_d(host_d),
    .sdio_wire(sdio_wire), .sdo_out(sdo_out), .sdo_oe(sdo_oe)
  );

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, rx);
  endtask

  task automatic rd(input logic [4:0] a);
    host.xfer(1'b1, a, 8'h00, rx);
  endtask

  task automatic t_defaults;
    pll_locked <= 1'b1;
    rd(5'h00);
    chk("port reg", 8'h02, rx);
    rd(5'h02);
    chk("control b", 8'h00, rx);
    rd(5'h07);
    chk("unmapped", 8'h00, rx);
    chk("enables", 8'h0F, {4'h0, cfg.circuitry_enable, cfg.second_port_enable,
        cfg.q_clock_enable, cfg.modulator_enable});
    $display("defaults done");
  endtask

  task automatic t_ctrl_a;
    wr(5'h04, 8'hA5);
    wr(5'h01, 8'hF7);
    chk("interp filter", 8'h3D, {2'b00, cfg.interp_factor, cfg.filter_mode});
    chk("zero stuff", 8'h01, {7'h00, cfg.zero_stuff_en});
    chk("delay off", 8'h00, {3'h0, cfg.data_clock_delay});
    wr(5'h02, 8'h10);
    chk("delay", 8'h1A, {3'h0, cfg.data_clock_delay});
    rd(5'h04);
    chk("delay low", 8'hA5, rx);
    wr(5'h01, 8'h00);
    chk("delay msb", 8'h0A, {3'h0, cfg.data_clock_delay});
    wr(5'h02, 8'h00);
    $display("control a done");
  endtask

  task automatic t_ctrl_b;
    transmit_enable_in <= 1'b1;
    wr(5'h02, 8'hEF);
    chk("b fields", 8'hD3, {cfg.data_format_unsigned, cfg.single_port, cfg.second_port_enable,
        cfg.real_mode, cfg.q_clock_enable, cfg.modulator_enable, cfg.inverse_sinc_en,
        cfg.data_clock_invert});
    chk("tx q order", 8'h06, {5'h00, cfg.tx_enable_invert, cfg.q_first,
        transmit_enable_eff});
    rd(5'h02);
    chk("control b", 8'hEF, rx);
    wr(5'h02, 8'h00);
    chk("b cleared", 8'h0F, {4'h0, cfg.second_port_enable, cfg.q_clock_enable,
        cfg.modulator_enable, transmit_enable_eff});
    $display("control b done");
  endtask

  task automatic t_port;
    pll_locked <= 1'b0;
    wr(5'h00, 8'h9B);
    host.bidir = 1'b1;
    rd(5'h00);
    chk("port bidir", 8'h98, rx);
    chk("power down", 8'h0C, {4'h0, cfg.power_down, cfg.auto_power_down_en,
        cfg.circuitry_enable, transmit_enable_eff});
    wr(5'h00, 8'h88);
    chk("auto on", 8'h01, {7'h00, cfg.circuitry_enable});
    transmit_enable_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("auto off", 8'h00, {7'h00, cfg.circuitry_enable});
    transmit_enable_in <= 1'b1;
    wr(5'h00, 8'h00);
    host.bidir = 1'b0;
    $display("port register done");
  endtask

  task automatic t_lsb_reset;
    wr(5'h00, 8'h40);
    host.lsb_first = 1'b1;
    wr(5'h01, 8'hC4);
    chk("lsb write", 8'h31, {2'b00, cfg.interp_factor, cfg.filter_mode});
    rd(5'h01);
    chk("lsb read", 8'hC4, rx);
    wr(5'h00, 8'h60);
    wr(5'h00, 8'h40);
    host.lsb_first = 1'b0;
    rd(5'h01);
    chk("reset a", 8'h00, rx);
    rd(5'h00);
    chk("reset port", 8'h00, rx);
    $display("soft reset done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_defaults;
    t_ctrl_a;
    t_ctrl_b;
    // A slower host for the rest
    host.half = 8;
    t_port;
    t_lsb_reset;
    tally_and_finish;
  end

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    tally_and_finish;
  end
endmodule
